// ==== src/cls_pkg.sv ====
// Constants and types of the packet classifier match block.
package cls_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_TOS = 8'h04;
  localparam logic [7:0] OFS_PROTO = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0c;
  localparam logic [7:0] OFS_SMASK = 8'h10;
  localparam logic [7:0] OFS_DST = 8'h14;
  localparam logic [7:0] OFS_DMASK = 8'h18;
  localparam logic [7:0] OFS_SPORT = 8'h1c;
  localparam logic [7:0] OFS_DPORT = 8'h20;
  localparam logic [7:0] OFS_FLOWID = 8'h24;
  localparam logic [7:0] OFS_GEN = 8'h28;
  localparam logic [7:0] OFS_ENCLEN = 8'h2c;
  localparam logic [7:0] OFS_CMD = 8'h30;
  localparam logic [7:0] OFS_FLOWACT = 8'h34;
  localparam logic [7:0] OFS_ERR = 8'h38;
  localparam logic [7:0] OFS_STAT = 8'h3c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned GEN_STATE_LSB = 8;
  localparam int unsigned GEN_ACT_LSB = 16;
  localparam int unsigned GEN_PRIO_P = 24;
  localparam int unsigned GEN_STATE_P = 25;
  localparam int unsigned GEN_SRC_P = 26;
  localparam int unsigned GEN_SMASK_P = 27;
  localparam int unsigned GEN_DST_P = 28;
  localparam int unsigned GEN_DMASK_P = 29;
  localparam int unsigned GEN_DYN = 30;
  localparam int unsigned GEN_FID_P = 31;
  localparam int unsigned TOS_HI_LSB = 8;
  localparam int unsigned TOS_MASK_LSB = 16;
  localparam int unsigned TOS_P = 24;
  localparam int unsigned PROTO_P = 16;
  localparam int unsigned PORT_HI_LSB = 16;
  localparam int unsigned ENC_KNOWN = 16;
  localparam int unsigned STAT_IPOK = 1;
  localparam int unsigned STAT_MSG_LSB = 8;
  localparam int unsigned STAT_VAL_LSB = 16;

  // ---------------------------------------------------------------
  // Values and defaults
  // ---------------------------------------------------------------
  localparam logic [7:0] PRIO_CFG_DEF = 8'h00;
  localparam logic [7:0] PRIO_DYN_MIN = 8'h40;
  localparam logic [7:0] PRIO_DYN_MAX = 8'hbf;
  localparam logic [7:0] STATE_ACTIVE = 8'h01;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;
  localparam logic [15:0] PORT_LO_DEF = 16'h0000;
  localparam logic [15:0] PORT_HI_DEF = 16'hffff;
  localparam logic [7:0] ACT_ADD = 8'h00;
  localparam logic [7:0] ACT_REPLACE = 8'h01;
  localparam logic [7:0] ACT_DELETE = 8'h02;
  localparam logic [15:0] PROTO_ANY = 16'h0100;
  localparam logic [15:0] PROTO_L4 = 16'h0101;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [15:0] ENC_LEN_LIMIT = 16'h0100;
  localparam logic [7:0] SUB_FID = 8'h04;
  localparam logic [7:0] SUB_PRIO = 8'h05;
  localparam logic [7:0] SUB_STATE = 8'h06;
  localparam logic [7:0] SUB_ACT = 8'h07;
  localparam logic [7:0] SUB_IP = 8'h09;
  localparam logic [7:0] SUB_IP_PROTO = 8'h02;
  localparam logic [3:0] PLEN_ONE = 4'h1;
  localparam logic [3:0] PLEN_TWO = 4'h2;
  localparam logic [7:0] CONF_REJECT = 8'h01;
  localparam logic [7:0] CONF_BAD_PARAM = 8'h02;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic active;
    logic [7:0] prio;
    logic tos_en;
    logic [7:0] tos_lo;
    logic [7:0] tos_hi;
    logic [7:0] tos_mask;
    logic proto_en;
    logic [15:0] proto;
    logic src_en;
    logic [31:0] src;
    logic [31:0] smask;
    logic dst_en;
    logic [31:0] dst;
    logic [31:0] dmask;
    logic [15:0] sp_lo;
    logic [15:0] sp_hi;
    logic [15:0] dp_lo;
    logic [15:0] dp_hi;
    logic [31:0] flow_id;
  } cls_entry_t;

  typedef struct packed {
    logic valid;
    logic [7:0] service_byte;
    logic [7:0] proto;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] sport;
    logic [15:0] dport;
  } cls_pkt_t;

  typedef struct packed {
    logic [7:0] code;
    logic [3:0] plen;
    logic [7:0] sub2;
    logic [7:0] sub1;
  } cls_err_t;

endpackage : cls_pkg

// ==== src/cls_match.sv ====
// Packet classifier table, commit checks, error encoding and match logic.
// Behaviour
// RULE_01: Flow identifier is 32-bit nonzero; present only where the flow is known.
// RULE_02: Higher one-octet priority wins; configured entries default to priority 0.
// RULE_03: Dynamic entries carry priority 64 to 191; omitted priority means 64.
// RULE_04: Activation state 0 is inactive, 1 active; missing state means active.
// RULE_05: An entry is used only when it and its flow are both active.
// RULE_06: Change action code 0 adds, 1 replaces, 2 deletes the entry.
// RULE_07: A failed request yields an error encoding with parameter and code.
// RULE_08: Errors only for rejected entries; none when the request succeeds.
// RULE_09: While an error encoding stands, no IP match encodings are reported.
// RULE_10: The requester never sends an error encoding inside a request.
// RULE_11: One errored parameter: length one names a subtype, two a pair.
// RULE_12: Exactly one error code, never the success value zero.
// RULE_13: At most one text item; its length counts the closing zero.
// RULE_14: Encodings of 256 bytes or more are malformed and rejected.
// RULE_15: Service byte ANDed with mask must lie within low and high.
// RULE_16: Protocol 256 matches all, 257 TCP or UDP, above 257 nothing.
// RULE_17: Masked source address must equal the configured source value.
// RULE_18: A missing source mask is taken as all ones.
// RULE_19: Masked destination must equal configured value; mask defaults to ones.
// RULE_20: TCP or UDP source port must be at least the low bound.
// RULE_21: TCP or UDP source port must be at most the high bound.
// RULE_22: TCP or UDP destination port must lie within its range.
// RULE_23: All present criteria must hold; highest priority matching entry wins.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cls_match #(
  parameter int unsigned NUM_ENTRIES = 4,
  parameter int unsigned MSG_CHARS = 0,
  parameter int unsigned IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire cls_pkg::cls_pkt_t pkt_in,
  output logic match_valid_out,
  output logic match_hit_out,
  output logic [IDX_W-1:0] match_index_out,
  output logic [7:0] match_prio_out
);
  import cls_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  cls_entry_t ent_q [NUM_ENTRIES];
  cls_entry_t stg_q;
  cls_entry_t new_w;
  cls_err_t err_q;
  cls_err_t err_d;
  logic [31:0] gen_q;
  logic [16:0] enclen_q;
  logic [IDX_W-1:0] sel_q;
  logic [NUM_ENTRIES-1:0] flow_act_q;
  logic err_present_q;
  logic ip_ok_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic mv_q;
  logic mh_q;
  logic [IDX_W-1:0] mi_q;
  logic [7:0] mp_q;

  // Defaults that omitted fields fall back to.
  function automatic cls_entry_t cls_stg_def();
    cls_entry_t e;
    e = '0;
    e.tos_mask = 8'hff;
    e.smask = MASK_ALL; // see RULE_18
    e.dmask = MASK_ALL; // see RULE_19
    e.sp_lo = PORT_LO_DEF; // see RULE_20
    e.sp_hi = PORT_HI_DEF; // see RULE_21
    e.dp_lo = PORT_LO_DEF; // see RULE_22
    e.dp_hi = PORT_HI_DEF; // see RULE_22
    return e;
  endfunction : cls_stg_def

  // Packet test against one entry's present criteria.
  function automatic logic cls_hit(input cls_entry_t e, input cls_pkt_t p);
    logic l4;
    logic [7:0] tb;
    logic ok;
    l4 = (p.proto == PROTO_TCP) || (p.proto == PROTO_UDP);
    tb = p.service_byte & e.tos_mask;
    ok = !e.tos_en || ((tb >= e.tos_lo) && (tb <= e.tos_hi)); // see RULE_15
    if (e.proto_en) begin
      if (e.proto == PROTO_L4) begin
        ok = ok && l4; // see RULE_16
      end else if (e.proto < PROTO_ANY) begin
        ok = ok && (e.proto[7:0] == p.proto); // see RULE_16
      end
    end
    ok = ok && (!e.src_en || ((p.src & e.smask) == e.src)); // see RULE_17
    ok = ok && (!e.dst_en || ((p.dst & e.dmask) == e.dst)); // see RULE_19
    if (l4) begin
      ok = ok && (p.sport >= e.sp_lo); // see RULE_20
      ok = ok && (p.sport <= e.sp_hi); // see RULE_21
      ok = ok && (p.dport >= e.dp_lo) && (p.dport <= e.dp_hi); // see RULE_22
    end
    return ok;
  endfunction : cls_hit

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire acc_w = (avs_read_in || avs_write_in) && !wait_q;
  wire wr_w = acc_w && avs_write_in;
  wire cmd_w = wr_w && (avs_address_in == OFS_CMD);

  // ---------------------------------------------------------------
  // Commit checks
  // ---------------------------------------------------------------
  wire [7:0] g_prio = gen_q[7:0];
  wire [7:0] g_state = gen_q[GEN_STATE_LSB +: 8];
  wire [7:0] g_act = gen_q[GEN_ACT_LSB +: 8];
  wire g_dyn = gen_q[GEN_DYN];
  wire g_fid_p = gen_q[GEN_FID_P];
  wire g_known = enclen_q[ENC_KNOWN];
  wire [7:0] prio_eff = gen_q[GEN_PRIO_P] ? g_prio :
                        (g_dyn ? PRIO_DYN_MIN : PRIO_CFG_DEF); // see RULE_02 RULE_03
  wire bad_len = enclen_q[15:0] >= ENC_LEN_LIMIT; // see RULE_14
  wire bad_act = g_dyn && (g_act > ACT_DELETE); // see RULE_06
  wire bad_fid = (g_known != g_fid_p) || (g_fid_p && (stg_q.flow_id == 32'h0)); // see RULE_01
  wire bad_prio = g_dyn && ((prio_eff < PRIO_DYN_MIN) || (prio_eff > PRIO_DYN_MAX)); // see RULE_03
  wire bad_state = gen_q[GEN_STATE_P] && (g_state > STATE_ACTIVE); // see RULE_04
  wire bad_proto = g_dyn && stg_q.proto_en && (stg_q.proto > PROTO_L4);
  wire bad_any = bad_len || bad_act || bad_fid || bad_prio || bad_state || bad_proto;
  wire do_del = g_dyn && (g_act == ACT_DELETE); // see RULE_06

  // Error encoding: one parameter, one nonzero code.
  always_comb begin
    err_d = '0;
    err_d.code = CONF_BAD_PARAM; // see RULE_12
    err_d.plen = PLEN_ONE; // see RULE_11
    if (bad_len) begin
      err_d.sub1 = SUB_IP;
      err_d.code = CONF_REJECT;
    end else if (bad_act) begin
      err_d.sub1 = SUB_ACT;
    end else if (bad_fid) begin
      err_d.sub1 = SUB_FID;
    end else if (bad_prio) begin
      err_d.sub1 = SUB_PRIO;
    end else if (bad_state) begin
      err_d.sub1 = SUB_STATE;
    end else begin
      err_d.plen = PLEN_TWO; // see RULE_11
      err_d.sub1 = SUB_IP;
      err_d.sub2 = SUB_IP_PROTO;
    end
  end

  // Staged fields turned into a table entry.
  always_comb begin
    new_w = stg_q;
    new_w.valid = 1'b1;
    new_w.prio = prio_eff;
    new_w.active = !gen_q[GEN_STATE_P] || (g_state == STATE_ACTIVE); // see RULE_04
    new_w.src_en = gen_q[GEN_SRC_P]; // see RULE_17
    new_w.smask = gen_q[GEN_SMASK_P] ? stg_q.smask : MASK_ALL; // see RULE_18
    new_w.dst_en = gen_q[GEN_DST_P];
    new_w.dmask = gen_q[GEN_DMASK_P] ? stg_q.dmask : MASK_ALL; // see RULE_19
  end

  // ---------------------------------------------------------------
  // Match
  // ---------------------------------------------------------------
  logic [NUM_ENTRIES-1:0] use_w;
  logic [NUM_ENTRIES-1:0] hit_w;
  logic [NUM_ENTRIES-1:0] vld_w;
  logic best_hit;
  logic [IDX_W-1:0] best_idx;
  logic [7:0] best_prio;

  for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_ent
    assign vld_w[i] = ent_q[i].valid;
    assign use_w[i] = ent_q[i].valid && ent_q[i].active && flow_act_q[i] &&
                      !(ent_q[i].proto_en && (ent_q[i].proto > PROTO_L4)); // see RULE_05 RULE_16
    assign hit_w[i] = use_w[i] && cls_hit(ent_q[i], pkt_in); // see RULE_23
  end

  // Highest priority wins; the lower index wins a tie.
  always_comb begin
    best_hit = 1'b0;
    best_idx = '0;
    best_prio = '0;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (hit_w[i] && (!best_hit || (ent_q[i].prio > best_prio))) begin // see RULE_02 RULE_23
        best_hit = 1'b1;
        best_idx = IDX_W'(i);
        best_prio = ent_q[i].prio;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [7:0] msg_len = (MSG_CHARS == 0) ? 8'h00 : 8'(MSG_CHARS + 1); // see RULE_13
  wire [31:0] stat_w = {8'h00, 8'(vld_w), msg_len, 6'h00, ip_ok_q, err_present_q};

  always_comb begin
    case (avs_address_in)
      OFS_SEL: rd_mux = 32'(sel_q);
      OFS_FLOWID: rd_mux = stg_q.flow_id;
      OFS_GEN: rd_mux = gen_q;
      OFS_ENCLEN: rd_mux = 32'(enclen_q);
      OFS_FLOWACT: rd_mux = 32'(flow_act_q);
      OFS_ERR: rd_mux = 32'(err_q); // see RULE_07
      OFS_STAT: rd_mux = stat_w;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !((avs_read_in || avs_write_in) && wait_q);
      if (avs_read_in && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Staging and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      stg_q <= cls_stg_def();
      gen_q <= 32'h00000000;
      enclen_q <= '0;
      sel_q <= '0;
      flow_act_q <= '0;
    end else if (cmd_w) begin
      stg_q <= cls_stg_def();
      gen_q <= 32'h00000000;
    end else if (wr_w) begin
      case (avs_address_in)
        OFS_SEL: sel_q <= avs_writedata_in[IDX_W-1:0];
        OFS_TOS: begin
          stg_q.tos_lo <= avs_writedata_in[7:0];
          stg_q.tos_hi <= avs_writedata_in[TOS_HI_LSB +: 8];
          stg_q.tos_mask <= avs_writedata_in[TOS_MASK_LSB +: 8];
          stg_q.tos_en <= avs_writedata_in[TOS_P];
        end
        OFS_PROTO: begin
          stg_q.proto <= avs_writedata_in[15:0];
          stg_q.proto_en <= avs_writedata_in[PROTO_P];
        end
        OFS_SRC: stg_q.src <= avs_writedata_in;
        OFS_SMASK: stg_q.smask <= avs_writedata_in;
        OFS_DST: stg_q.dst <= avs_writedata_in;
        OFS_DMASK: stg_q.dmask <= avs_writedata_in;
        OFS_SPORT: begin
          stg_q.sp_lo <= avs_writedata_in[15:0];
          stg_q.sp_hi <= avs_writedata_in[PORT_HI_LSB +: 16];
        end
        OFS_DPORT: begin
          stg_q.dp_lo <= avs_writedata_in[15:0];
          stg_q.dp_hi <= avs_writedata_in[PORT_HI_LSB +: 16];
        end
        OFS_FLOWID: stg_q.flow_id <= avs_writedata_in;
        OFS_GEN: gen_q <= avs_writedata_in;
        OFS_ENCLEN: enclen_q <= avs_writedata_in[16:0];
        OFS_FLOWACT: flow_act_q <= avs_writedata_in[NUM_ENTRIES-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Table update and error state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        ent_q[i] <= cls_stg_def();
      end
      err_q <= '0;
      err_present_q <= 1'b0;
      ip_ok_q <= 1'b1;
    end else if (cmd_w) begin
      if (bad_any) begin
        err_q <= err_d; // see RULE_07 RULE_08
        err_present_q <= 1'b1;
        ip_ok_q <= 1'b0; // see RULE_09
      end else begin
        err_q <= '0; // see RULE_08
        err_present_q <= 1'b0;
        ip_ok_q <= 1'b1;
        if (do_del) begin
          ent_q[sel_q].valid <= 1'b0; // see RULE_06
        end else begin
          ent_q[sel_q] <= new_w; // see RULE_06
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Match result
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      mv_q <= 1'b0;
      mh_q <= 1'b0;
      mi_q <= '0;
      mp_q <= 8'h00;
    end else begin
      mv_q <= pkt_in.valid;
      mh_q <= pkt_in.valid && best_hit;
      mi_q <= best_idx;
      mp_q <= best_prio;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign match_valid_out = mv_q;
  assign match_hit_out = mh_q;
  assign match_index_out = mi_q;
  assign match_prio_out = mp_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_err_code_nonzero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_12
    err_present_q |-> (err_q.code != 8'h00))
    else $error("error encoding holds a zero code");

  a_err_param_len: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_11
    err_present_q |-> ((err_q.plen == PLEN_ONE && err_q.sub2 == 8'h00) || err_q.plen == PLEN_TWO))
    else $error("errored parameter length is wrong");

  a_err_no_ip: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_09
    err_present_q |-> !stat_w[STAT_IPOK])
    else $error("IP encodings reported beside an error");

  a_ok_clears_err: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_08
    (cmd_w && !bad_any) |=> (!err_present_q && err_q == '0))
    else $error("error kept after a good request");

  a_long_rejected: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_14
    (cmd_w && enclen_q[15:0] >= ENC_LEN_LIMIT) |=> (err_present_q && $stable(ent_q[sel_q])))
    else $error("malformed encoding accepted");

  a_dyn_prio_range: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_03
    (cmd_w && g_dyn && gen_q[GEN_PRIO_P] && g_prio > PRIO_DYN_MAX) |=> err_present_q)
    else $error("dynamic priority above range accepted");

  a_delete_entry: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_06
    (cmd_w && !bad_any && do_del) |=> !ent_q[$past(sel_q)].valid)
    else $error("delete left the entry valid");

  a_hit_usable: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_05
    match_hit_out |-> $past(use_w[best_idx]) && $past(flow_act_q[best_idx]))
    else $error("hit on an unusable entry");

  a_hit_follows_pkt: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_23
    (pkt_in.valid && best_hit) |=> (match_hit_out && match_prio_out == $past(best_prio)))
    else $error("matching packet not reported");

  a_fid_zero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see RULE_01
    (cmd_w && g_fid_p && stg_q.flow_id == 32'h0) |=> (err_present_q && err_q.sub1 != SUB_ACT))
    else $error("zero flow identifier accepted");

endmodule : cls_match

`default_nettype wire

// ==== tb/cls_pkt_src.sv ====
// Packet header source feeding the classifier's packet port.
`timescale 1ns/10ps
`default_nettype none

module cls_pkt_src (
  input wire logic clk_sys_in,
  output var cls_pkg::cls_pkt_t pkt_out
);
  import cls_pkg::*;
  initial pkt_out = '0;
  // One header for one cycle; then the fields flip so stale values never match.
  task automatic send(input cls_pkt_t p);
    @(posedge clk_sys_in);
    pkt_out <= p;
    @(posedge clk_sys_in);
    pkt_out <= {1'b0, ~p[111:0]};
  endtask : send
endmodule : cls_pkt_src
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the packet classifier match block.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import cls_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, rdq;
  logic avs_waitrequest_out, match_valid_out, match_hit_out;
  logic [1:0] match_index_out;
  logic [7:0] match_prio_out;
  cls_pkt_t pkt_in;
  int n_fail = 0;
  int checks_done = 0;

  cls_match cls_match_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pkt_in(pkt_in),
    .match_valid_out(match_valid_out), .match_hit_out(match_hit_out),
    .match_index_out(match_index_out), .match_prio_out(match_prio_out));
  cls_pkt_src cls_pkt_src_inst (.clk_sys_in(clk_sys_in), .pkt_out(pkt_in));

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ---------------------------------------------------------------
  // Bus and packet helpers
  // ---------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rdq = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n == 20) begin
      n_fail++;
      end_sim();
    end
  endtask : acc

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, rdq, exp);
  endtask : rchk

  task automatic cm(input logic [31:0] sel, input logic [31:0] gen, input logic [31:0] len);
    acc(1'b1, OFS_SEL, sel);
    acc(1'b1, OFS_GEN, gen);
    acc(1'b1, OFS_ENCLEN, len);
    acc(1'b1, OFS_CMD, 32'h0);
  endtask : cm

  // Expected e holds hit in bit 10, index in bits 9:8 and priority in bits 7:0.
  task automatic pk(input logic [7:0] sb, input logic [7:0] pr, input logic [31:0] src,
                    input logic [31:0] dst, input logic [15:0] sp, input logic [10:0] e);
    cls_pkt_src_inst.send({1'b1, sb, pr, src, dst, sp, 16'h0050});
    @(posedge clk_sys_in);
    chk("match", {20'h0, match_valid_out, match_hit_out, match_index_out,
        e[10] ? match_prio_out : 8'h00}, {20'h0, 1'b1, e});
  endtask : pk

  task automatic t_reset;
    rchk("stat", OFS_STAT, 32'h00000002);
    rchk("err", OFS_ERR, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    acc(1'b1, OFS_FLOWID, 32'h89abcdef);
    rchk("flowid", OFS_FLOWID, 32'h89abcdef);
  endtask : t_reset

  task automatic t_config;
    acc(1'b1, OFS_TOS, 32'h01f02010);
    acc(1'b1, OFS_PROTO, 32'h00010100);
    acc(1'b1, OFS_SRC, 32'h0a000001);
    acc(1'b1, OFS_FLOWACT, 32'h1);
    cm(32'h0, 32'h05000005, 32'h20);
    rchk("stat_cfg", OFS_STAT, 32'h00010002);
    pk(8'h1c, 8'h32, 32'h0a000001, 32'h0, 16'h0, 11'h405);
    pk(8'h2f, 8'h06, 32'h0a000001, 32'h0, 16'h0, 11'h405);
    pk(8'h3c, 8'h06, 32'h0a000001, 32'h0, 16'h0, 11'h000);
    pk(8'h1c, 8'h06, 32'h0a000002, 32'h0, 16'h0, 11'h000);
  endtask : t_config

  task automatic t_dynamic;
    acc(1'b1, OFS_PROTO, 32'h00010101);
    acc(1'b1, OFS_DST, 32'hc0a80000);
    acc(1'b1, OFS_DMASK, 32'hffffff00);
    acc(1'b1, OFS_SPORT, 32'h07d003e8);
    acc(1'b1, OFS_FLOWACT, 32'h3);
    cm(32'h1, 32'h70000000, 32'h20);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h540);
    pk(8'h00, 8'h11, 32'h0b000000, 32'hc0a80011, 16'h07d0, 11'h540);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e7, 11'h000);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h07d1, 11'h000);
    pk(8'h00, 8'h01, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h000);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a90011, 16'h03e8, 11'h000);
    pk(8'h1c, 8'h06, 32'h0a000001, 32'hc0a80011, 16'h03e8, 11'h540);
    acc(1'b1, OFS_FLOWACT, 32'h1);
    pk(8'h1c, 8'h06, 32'h0a000001, 32'hc0a80011, 16'h03e8, 11'h405);
    acc(1'b1, OFS_FLOWACT, 32'h3);
  endtask : t_dynamic

  task automatic t_errors;
    logic [31:0] gen[7] = '{32'h0, 32'h40030000, 32'h0, 32'h410000c8, 32'h02000200,
                            32'h40000000, 32'h80000000};
    logic [31:0] len[7] = '{32'h100, 32'h20, 32'h10020, 32'h20, 32'h20, 32'h20, 32'h10020};
    logic [31:0] err[7] = '{32'h00110009, 32'h00210007, 32'h00210004, 32'h00210005,
                            32'h00210006, 32'h00220209, 32'h00210004};
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, OFS_PROTO, 32'h00010102);
      cm(32'h2, gen[i], len[i]);
      rchk("err_code", OFS_ERR, err[i]);
      rchk("err_stat", OFS_STAT, 32'h00030001);
    end
    acc(1'b1, OFS_ERR, 32'h0);
    rchk("err_ro", OFS_ERR, 32'h00210004);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h540);
  endtask : t_errors

  task automatic t_state;
    acc(1'b1, OFS_FLOWACT, 32'h7);
    cm(32'h2, 32'h030000ff, 32'h20);
    rchk("err_clear", OFS_ERR, 32'h0);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h540);
    cm(32'h2, 32'h030001ff, 32'h20);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h6ff);
    acc(1'b1, OFS_FLOWACT, 32'h3);
    cm(32'h1, 32'h410200bf, 32'h20);
    rchk("stat_del", OFS_STAT, 32'h00050002);
    pk(8'h00, 8'h06, 32'h0b000000, 32'hc0a80011, 16'h03e8, 11'h000);
  endtask : t_state

  initial begin
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_reset();
    t_config();
    t_dynamic();
    t_errors();
    t_state();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
